/* dv/bus_register_address_decode_tb_top.sv */
`timescale 1ns/1ps
module bus_register_address_decode_tb_top;
    logic clk, srst, master_sync_n, wide_map_jumper, drive_transfer_n;
    logic nonexistent_drive_clear, device_select, legal_register;
    logic local_register_flag, local_register_strobe, demand_deskew;
    logic drive_demand, slave_sync, nonexistent_drive_flag, write_cycle;
    logic read_pause, low_byte_enable, high_byte_enable, resp_en, acc_done;
    logic [17:0] bus_addr_n, b;
    logic [1:0] bus_ctl_n;
    logic [7:0] base_jumper_removed, lookup_select_outputs;
    logic [3:0] count_jumper_removed, resp_dly;
    logic [9:0] seen, ex, mk;
    logic [19:0] note_q[$];
    int error_cnt = 0, compares = 0, seed = 69, n, i;
    bus_register_address_decode #(.STROBE_COUNT(3), .DESKEW_COUNT(4),
        .TIMEOUT_COUNT(10)) i_bus_register_address_decode (.clk, .srst,
        .bus_addr_n, .bus_ctl_n, .master_sync_n, .base_jumper_removed,
        .wide_map_jumper, .count_jumper_removed, .drive_transfer_n,
        .nonexistent_drive_clear, .device_select, .legal_register,
        .local_register_flag, .lookup_select_outputs, .local_register_strobe,
        .demand_deskew, .drive_demand, .slave_sync, .nonexistent_drive_flag,
        .write_cycle, .read_pause, .low_byte_enable, .high_byte_enable);
    drive_responder i_drive_responder (.clk, .srst, .enable(resp_en),
        .delay(resp_dly), .drive_demand, .drive_transfer_n);
    // Clock
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    task end_of_test;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // One bus access, expectation noted first
    task automatic acc(input logic [17:0] a, input logic [1:0] c,
                       input logic r);
        logic [4:0] idx;
        logic hit, lg, lc;
        logic [9:0] ex, mk;
        idx = {wide_map_jumper & a[5], a[4:1]};
        hit = &a[17:13] && (wide_map_jumper ?
            a[12:6] == base_jumper_removed[7:1] : a[12:5] == base_jumper_removed);
        lg = idx[4:1] < count_jumper_removed;
        lc = idx inside {5'h4, 5'h5, 5'h7, 5'h8};
        ex = {hit, hit && lg && (lc || r), hit && lg && lc, hit && lg && !lc,
            hit && lg && !lc && !r, c[1], c == 2'h1, c == 2'h3 && !a[0],
            c == 2'h3 && a[0], hit && lc};
        mk = !hit ? 10'h3e1 : !lg ? 10'h181 : c == 2'h3 ? 10'h3ff : 10'h3f9;
        note_q.push_back({ex, mk});
        bus_addr_n <= ~a;
        bus_ctl_n <= ~c;
        resp_en <= r;
        resp_dly <= 4'($random(seed)) & 4'h3;
        nonexistent_drive_clear <= 1'b1;
        @(posedge clk);
        nonexistent_drive_clear <= 1'b0;
        repeat (38) @(posedge clk);
        master_sync_n <= 1'b0;
        for (n = 0; n < 60 && slave_sync !== 1'b1; n++) @(posedge clk);
        master_sync_n <= 1'b1;
        repeat (8) @(posedge clk);
        acc_done <= 1'b1;
        @(posedge clk);
        acc_done <= 1'b0;
    endtask
    // Gather outputs per access, compare with oldest note at its end
    always @(posedge clk) begin
        if (acc_done) begin
            compares++;
            {ex, mk} = note_q.pop_front();
            if (((seen ^ ex) & mk) !== 10'h0) begin
                error_cnt++;
                $display("BAD access exp %h seen %h", ex & mk, seen & mk);
            end
        end
        // Level outputs only count while selected, so that the previous
        // access's decode does not leak into this one
        seen <= (srst || acc_done) ? 10'h0 : seen | {device_select,
            slave_sync, local_register_strobe, drive_demand,
            {nonexistent_drive_flag, write_cycle, read_pause,
            low_byte_enable, high_byte_enable, lookup_select_outputs[5]} &
            {6{device_select}}};
    end
    // Watchdog
    initial begin
        #100000;
        error_cnt++;
        end_of_test;
    end
    initial begin
        srst = 1;
        master_sync_n = 1;
        bus_addr_n = '1;
        bus_ctl_n = '1;
        wide_map_jumper = 0;
        nonexistent_drive_clear = 0;
        resp_en = 0;
        resp_dly = 0;
        acc_done = 0;
        count_jumper_removed = 4'h4;
        base_jumper_removed = 8'($random(seed)) | 8'h1;
        b = {5'h1f, base_jumper_removed | 8'h1, 5'h0};
        repeat (2) @(posedge clk);
        srst <= 0;
        repeat (3) @(posedge clk);
        for (i = 0; i < 4; i++) acc(b | 18'h8, 2'(i), 1);
        acc(b | 18'h9, 2'h3, 1);
        $display("test control codes done");
        acc(b, 2'h2, 1);
        acc(b, 2'h0, 0);
        $display("test remote done");
        acc(b | 18'he, 2'h0, 1);
        acc(b | 18'h10, 2'h2, 1);
        count_jumper_removed <= 4'h5;
        @(posedge clk);
        acc(b | 18'h10, 2'h2, 1);
        $display("test limits done");
        acc(b ^ 18'h8008, 2'h0, 1);
        acc((b & ~18'h20) | 18'h8, 2'h0, 1);
        wide_map_jumper <= 1;
        @(posedge clk);
        acc((b & ~18'h20) | 18'h8, 2'h2, 1);
        count_jumper_removed <= 4'hf;
        @(posedge clk);
        acc(b | 18'h8, 2'h0, 1);
        $display("test decode done");
        end_of_test;
    end
endmodule
bind bus_register_address_decode regsel_sva #(.DESKEW_COUNT(DESKEW_COUNT))
    i_regsel_sva (.clk, .srst, .bus_addr_n, .master_sync_n,
    .drive_transfer_n, .device_select, .legal_register, .local_register_flag,
    .local_register_strobe, .demand_deskew, .drive_demand, .slave_sync,
    .nonexistent_drive_flag);

/* dv/drive_responder.sv */
`timescale 1ns/1ps
module drive_responder (
    input wire logic clk,
    input wire logic srst,
    input wire logic enable,
    input wire logic [3:0] delay,
    input wire logic drive_demand,
    output logic drive_transfer_n
);
    logic [3:0] wait_reg;
    // Answer demand after delay, release high when demand drops
    always_ff @(posedge clk) begin
        if (srst || !drive_demand) begin
            wait_reg <= 4'h0;
            drive_transfer_n <= 1'b1;
        end else if (enable && wait_reg == delay) begin
            drive_transfer_n <= 1'b0;
        end else if (enable) begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule

/* dv/regsel_sva.sv */
`timescale 1ns/1ps
module regsel_sva #(
    parameter int DESKEW_COUNT = 55
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [17:0] bus_addr_n,
    input wire logic master_sync_n,
    input wire logic drive_transfer_n,
    input wire logic device_select,
    input wire logic legal_register,
    input wire logic local_register_flag,
    input wire logic local_register_strobe,
    input wire logic demand_deskew,
    input wire logic drive_demand,
    input wire logic slave_sync,
    input wire logic nonexistent_drive_flag
);
    localparam int DEM_MAX = DESKEW_COUNT + 8;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Remote cycle steps
    sequence remote_go;
        $rose(demand_deskew);
    endsequence
    sequence demand_up;
        ##[1:DEM_MAX] drive_demand;
    endsequence
    page_match_a: assert property (
        device_select |-> $past(bus_addr_n[17:13], 2) == 5'h0)
        else $error("select outside the I/O page");
    strobe_local_a: assert property (
        local_register_strobe |->
        device_select && local_register_flag && legal_register)
        else $error("strobe without a local legal select");
    strobe_pulse_a: assert property (
        local_register_strobe |=> !local_register_strobe)
        else $error("strobe longer than one cycle");
    local_inhibit_a: assert property (
        device_select && local_register_flag |->
        !demand_deskew && !drive_demand)
        else $error("drive handshake on a local register");
    deskew_demand_a: assert property (
        remote_go |-> demand_up)
        else $error("demand missing after deskew");
    demand_remote_a: assert property (
        $rose(drive_demand) |-> !local_register_flag && $past(demand_deskew))
        else $error("demand without remote deskew");
    ssyn_legal_a: assert property (
        slave_sync |-> device_select && legal_register)
        else $error("slave sync without legal select");
    cycle_release_a: assert property (
        $rose(master_sync_n) |-> ##[1:6]
        (!device_select && !local_register_strobe && !slave_sync))
        else $error("cycle not released after sync");
    drive_missing_a: assert property (
        $rose(nonexistent_drive_flag) |->
        $past(drive_demand) && $past(drive_transfer_n))
        else $error("missing drive flag without demand");
endmodule

/* hdl/bus_register_address_decode.sv */
`timescale 1ns/1ps
// How it works
// - Access only when address bits 17..13 all asserted (I/O page).
// - Bits 12..5 compared with base jumpers; any mismatch blocks select.
// - Installed jumper means zero, removed jumper means one.
// - Bus address lines are active low and inverted before compare.
// - Bits 4..1 index a 32-cell lookup, fifth input low by default.
// - Each lookup cell gives an eight-bit select pattern per register.
// - Over 16 registers: bit 5 feeds lookup, leaves base compare.
// - Top four index bits compared to register count; below count valid.
// - At or past count: legal_register low, no slave sync.
// - Master sync qualifies match into device_select, starts strobing.
// - Local register: local flag set, drive handshake inhibited.
// - Drive register: local flag clear, demand sent to drive.
// - First control word decodes remote so drive portion is reachable.
// - Local register strobe issued 85 ns after master sync.
// - Remote: demand follows 220 ns deskew after device select.
// - No drive response within 1.5 us sets nonexistent drive flag.
// - C1 C0: read, read-pause, write, byte write; A0 picks byte.
module bus_register_address_decode
    import regsel_pkg::*;
#(
    parameter int STROBE_COUNT = STROBE_CYCLES,
    parameter int DESKEW_COUNT = DESKEW_CYCLES,
    parameter int TIMEOUT_COUNT = RESP_TIMEOUT_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [17:0] bus_addr_n,
    input wire logic [1:0] bus_ctl_n,
    input wire logic master_sync_n,
    input wire logic [7:0] base_jumper_removed,
    input wire logic wide_map_jumper,
    input wire logic [3:0] count_jumper_removed,
    input wire logic drive_transfer_n,
    input wire logic nonexistent_drive_clear,
    output logic device_select,
    output logic legal_register,
    output logic local_register_flag,
    output logic [7:0] lookup_select_outputs,
    output logic local_register_strobe,
    output logic demand_deskew,
    output logic drive_demand,
    output logic slave_sync,
    output logic nonexistent_drive_flag,
    output logic write_cycle,
    output logic read_pause,
    output logic low_byte_enable,
    output logic high_byte_enable
);
    lookup_if lk ();
    select_lookup_rom rom_inst (
        .clk(clk),
        .port(lk)
    );

    // Pin synchronisers
    logic [17:0] addr_s1_reg, addr_s2_reg;
    logic [1:0] ctl_s1_reg, ctl_s2_reg;
    logic msyn_s1_reg, msyn_s2_reg;
    logic trans_s1_reg, trans_s2_reg;
    logic [7:0] base_s1_reg, base_s2_reg;
    logic [3:0] count_s1_reg, count_s2_reg;
    logic wide_s1_reg, wide_s2_reg;
    always_ff @(posedge clk) begin
        addr_s1_reg <= bus_addr_n;
        addr_s2_reg <= addr_s1_reg;
        ctl_s1_reg <= bus_ctl_n;
        ctl_s2_reg <= ctl_s1_reg;
        msyn_s1_reg <= master_sync_n;
        msyn_s2_reg <= msyn_s1_reg;
        trans_s1_reg <= drive_transfer_n;
        trans_s2_reg <= trans_s1_reg;
        // Jumpers are pins too
        base_s1_reg <= base_jumper_removed;
        base_s2_reg <= base_s1_reg;
        count_s1_reg <= count_jumper_removed;
        count_s2_reg <= count_s1_reg;
        wide_s1_reg <= wide_map_jumper;
        wide_s2_reg <= wide_s1_reg;
    end

    logic [17:0] addr;
    logic [1:0] ctl;
    logic msyn, trans;
    assign addr = ~addr_s2_reg;
    assign ctl = ~ctl_s2_reg;
    assign msyn = ~msyn_s2_reg;
    assign trans = ~trans_s2_reg;

    logic page_hit;
    assign page_hit = &addr[PAGE_MSB:PAGE_LSB];

    // per-bit base compare, masks bit 5 only in wide map
    logic [7:0] bit_match;
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_cmp
            if (g == 0) begin : g_b5
                assign bit_match[g] = wide_s2_reg ||
                    (addr[BASE_LSB + g] == base_s2_reg[g]);
            end else begin : g_bn
                assign bit_match[g] =
                    addr[BASE_LSB + g] == base_s2_reg[g];
            end
        end
    endgenerate
    logic addr_match;
    assign addr_match = page_hit && (&bit_match);

    // lookup index, fifth input low unless wide map
    logic [4:0] index;
    assign index = {wide_s2_reg & addr[BASE_LSB],
                    addr[INDEX_MSB:INDEX_LSB]};
    assign lk.index = index;

    // register count limit on top four index bits
    logic in_range;
    assign in_range = index[4:1] < count_s2_reg;

    // Slave cycle machine
    cycle_state_type state_reg;
    logic [$clog2(TIMEOUT_COUNT + 1)-1:0] count_reg;
    logic is_local;
    assign is_local = lk.data[SEL_LOCAL_BIT];

    // select follows qualified match, drops with sync
    always_ff @(posedge clk) begin
        if (srst) begin
            device_select <= 1'b0;
        end else begin
            device_select <= msyn && addr_match;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= ST_IDLE;
            count_reg <= '0;
        end else if (!msyn) begin
            state_reg <= ST_IDLE;
            count_reg <= '0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    count_reg <= '0;
                    if (device_select && legal_register) begin
                        state_reg <= is_local ? ST_LOCAL_WAIT : ST_DESKEW;
                    end
                end
                ST_LOCAL_WAIT: begin
                    count_reg <= count_reg + 1'b1;
                    if (count_reg >= STROBE_COUNT - 2) begin
                        state_reg <= ST_LOCAL_DONE;
                    end
                end
                ST_LOCAL_DONE: begin
                    state_reg <= ST_LOCAL_DONE;
                end
                ST_DESKEW: begin
                    count_reg <= count_reg + 1'b1;
                    if (count_reg >= DESKEW_COUNT - 2) begin
                        state_reg <= ST_DEMAND;
                        count_reg <= '0;
                    end
                end
                ST_DEMAND: begin
                    count_reg <= count_reg + 1'b1;
                    if (trans || count_reg >= TIMEOUT_COUNT - 1) begin
                        state_reg <= ST_FINISH;
                    end
                end
                ST_FINISH: begin
                    state_reg <= ST_FINISH;
                end
                // Unused codes fall back to idle
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // nonexistent drive flag, set wins over clear
    always_ff @(posedge clk) begin
        if (srst) begin
            nonexistent_drive_flag <= 1'b0;
        end else if (msyn && state_reg == ST_DEMAND && !trans &&
                     count_reg >= TIMEOUT_COUNT - 1) begin
            nonexistent_drive_flag <= 1'b1;
        end else if (nonexistent_drive_clear) begin
            nonexistent_drive_flag <= 1'b0;
        end
    end

    // Registered decode outputs
    always_ff @(posedge clk) begin
        if (srst) begin
            legal_register <= 1'b0;
            local_register_flag <= 1'b0;
            lookup_select_outputs <= 8'h00;
            write_cycle <= 1'b0;
            read_pause <= 1'b0;
            low_byte_enable <= 1'b0;
            high_byte_enable <= 1'b0;
        end else begin
            legal_register <= addr_match && in_range;
            local_register_flag <= is_local;
            lookup_select_outputs <= lk.data;
            write_cycle <= ctl[1];
            read_pause <= ctl == CTL_READ_PAUSE;
            low_byte_enable <= ctl != CTL_BYTE_WRITE || !addr[0];
            high_byte_enable <= ctl != CTL_BYTE_WRITE || addr[0];
        end
    end

    // strobe, deskew, demand and slave sync
    always_ff @(posedge clk) begin
        if (srst) begin
            local_register_strobe <= 1'b0;
            demand_deskew <= 1'b0;
            drive_demand <= 1'b0;
            slave_sync <= 1'b0;
        end else begin
            local_register_strobe <= msyn && state_reg == ST_LOCAL_WAIT &&
                count_reg >= STROBE_COUNT - 2;
            demand_deskew <= msyn && state_reg == ST_DESKEW;
            drive_demand <= msyn && state_reg == ST_DEMAND && !trans;
            // slave sync only for legal accesses, held until sync drops
            slave_sync <= msyn && legal_register &&
                (state_reg == ST_LOCAL_DONE ||
                 (state_reg == ST_DEMAND && trans) ||
                 (state_reg == ST_FINISH && slave_sync));
        end
    end
endmodule

/* hdl/lookup_if.sv */
`timescale 1ns/1ps
interface lookup_if;
    logic [4:0] index;
    logic [7:0] data;
    modport requester (output index, input data);
    modport memory (input index, output data);
endinterface

/* hdl/regsel_pkg.sv */
package regsel_pkg;
    // Clock period in picoseconds
    localparam int CLK_PERIOD_PS = 4000;
    // Strobe delay after master sync, ns
    localparam int STROBE_DELAY_NS = 85;
    localparam int STROBE_CYCLES =
        (STROBE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Deskew before demand, ns
    localparam int DESKEW_NS = 220;
    localparam int DESKEW_CYCLES =
        (DESKEW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Drive response timeout, ns
    localparam int RESP_TIMEOUT_NS = 1500;
    localparam int RESP_TIMEOUT_CYCLES =
        (RESP_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
    // Address field layout
    localparam int PAGE_MSB = 17;
    localparam int PAGE_LSB = 13;
    localparam int BASE_MSB = 12;
    localparam int BASE_LSB = 5;
    localparam int INDEX_MSB = 4;
    localparam int INDEX_LSB = 1;
    // Lookup select output bit positions
    localparam int SEL_LOCAL_BIT = 5;
    localparam int SEL_RSEL_MSB = 4;
    // Control line codes
    typedef enum logic [1:0] {
        CTL_WORD_READ = 2'h0,
        CTL_READ_PAUSE = 2'h1,
        CTL_WORD_WRITE = 2'h2,
        CTL_BYTE_WRITE = 2'h3
    } bus_ctl_type;
    // Slave cycle states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOCAL_WAIT,
        ST_LOCAL_DONE,
        ST_DESKEW,
        ST_DEMAND,
        ST_FINISH
    } cycle_state_type;
endpackage

/* hdl/select_lookup_rom.sv */
`timescale 1ns/1ps
module select_lookup_rom
    import regsel_pkg::*;
(
    input wire logic clk,
    lookup_if.memory port
);
    // Registered ROM read; 32 cells of select patterns
    logic [7:0] data_reg;
    logic [7:0] cell_type_tbl [0:31];

    // Cell contents: bit 5 local flag, bits 4:0 drive register select
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            cell_type_tbl[i] = 8'(i);
        end
        // Cell 0 is the shared control word: stays remote
        cell_type_tbl[4] = 8'h20;
        cell_type_tbl[5] = 8'h21;
        cell_type_tbl[7] = 8'h22;
        cell_type_tbl[8] = 8'h60;
    end

    always_ff @(posedge clk) begin
        data_reg <= cell_type_tbl[port.index];
    end

    assign port.data = data_reg;
endmodule
